// ==== common/charger_status_consts.svh ====
// constant definitions for the charger status upper-flag block
`ifndef CHARGER_STATUS_CONSTS_SVH
`define CHARGER_STATUS_CONSTS_SVH

// control word fields
`define CTRL_LEARN_BIT 4
`define CTRL_DEP_LSB 9
`define CTRL_DEP_MSB 11

// status word bit positions
`define ST_DEPLETED_BIT 11
`define ST_VOR_BIT 12
`define ST_ADP_LOW_BIT 13
`define ST_BAT_PRES_BIT 14
`define ST_ADP_PRES_BIT 15

// reset values
`define STATUS_RESET 16'h0000
`define VOLT_RESET 16'h0000
`define TARGET_RESET 16'h0000

// charge-voltage settings in millivolts
`define VOLT_WAKE_MV 16'h2328
`define BAND_LO_MIN_MV 16'h2EE0
`define BAND_LO_MAX_MV 16'h3840
`define BAND_HI_MIN_MV 16'h3E80
`define BAND_HI_MAX_MV 16'h4B00
`define DAC_STEP_MASK 16'hFFF0

// cell counts for the two bands
`define CELLS_LO 3'h3
`define CELLS_HI 3'h4

// per-cell depleted threshold: base plus code times step, in millivolts
`define DEP_BASE_MV 16'h0A8C
`define DEP_STEP_MV 16'h0064

// comparator margins in millivolts
`define REV_MARGIN_MV 17'h0_0096
`define HYST_MV 17'h0_0064
`define SYS_MARGIN_MV 17'h0_0096

// deglitch time and clock period
`define DEGLITCH_MS 8
`define CLK_PERIOD_NS 5
`define DEGLITCH_CYCLES ((`DEGLITCH_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ==== common/charger_status_pkg.sv ====
// types shared by the charger status upper-flag block
package charger_status_pkg;

  // bypass switch control states
  typedef enum logic [1:0] {
    BYP_OFF = 2'b00,
    BYP_WAIT = 2'b01,
    BYP_ON = 2'b10
  } bypass_state_t;

  // raw comparator levels arriving from the analog side
  typedef struct packed {
    logic ts_below;   // thermistor pin under battery-detect threshold
    logic adet_above; // adapter detect pin over 2.4 V threshold
    logic adet_wake;  // adapter detect pin over 1.2 V
    logic vcc_ok;     // supply over 6.5 V
  } pin_bits_t;

  // digitised rail levels in millivolts
  typedef struct packed {
    logic [15:0] bat_mv;
    logic [15:0] acp_mv;
    logic [15:0] sys_mv;
  } rail_levels_t;

  // switch drives and enables
  typedef struct packed {
    logic bat_drive;
    logic ac_drive;
    logic bypass_drive;
    logic charge_en;
    logic alarm;
    logic smbus_en;
    logic por_start;
  } drive_bits_t;

  // state of the top module apart from the reset synchroniser and the deglitch timer
  typedef struct packed {
    pin_bits_t sync1;
    pin_bits_t sync2;
    logic [15:0] volt_reg;
    logic [15:0] target_reg;
    logic vor_reg;
    logic [15:0] status_reg;
    bypass_state_t byp_reg;
    drive_bits_t drv_reg;
  } status_state_t;

endpackage : charger_status_pkg

// ==== logic/charger_status_upper.sv ====
// status flags 11 to 15 of the charger status word and their protection actions
`include "charger_status_consts.svh"

// Summary of operation
// - bit 11 high while battery below depleted threshold
// - threshold per cell, times three or four
// - learn and depleted: battery off, adapter on
// - bit 12 high for out-of-range voltage setting
// - accept 9 V and bands, truncate steps
// - above maximum: keep charging, clamp to maximum
// - low or gap setting: disable, flag, alarm
// - 9 V code regulates to 9 V
// - bit 13 high while battery above adapter
// - adapter under battery plus margin: bypass off
// - bypass back on after deglitch and hysteresis
// - bit 14 follows thermistor battery-detect comparator
// - no battery stops charging at once
// - bit 15 high while adapter detect above threshold
// - no charging until adapter detected
// - regulator reset and bus need wake levels
// - battery switch off while system rail high
module charger_status_upper #(
  parameter int DEGLITCH_CYCLES = `DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // register file side
  input wire logic [15:0] CTRL_WORD_IN,
  input wire logic VOLT_WR_IN,
  input wire logic [15:0] VOLT_DATA_IN,
  output logic [15:0] VOLT_WORD_OUT,
  output logic [15:0] STATUS_WORD_OUT,
  // analog side
  input wire charger_status_pkg::rail_levels_t RAILS_IN,
  input wire charger_status_pkg::pin_bits_t PINS_IN,
  // regulation and switch controls
  output logic [15:0] REG_TARGET_MV_OUT,
  output charger_status_pkg::drive_bits_t DRIVES_OUT
);
  import charger_status_pkg::*;

  // reset release synchroniser
  logic rst_meta_reg;
  logic rst_n;

  // state and next state
  status_state_t st_reg;
  status_state_t st_next;

  // decoded conditions
  logic learn_mode;
  logic [2:0] dep_code;
  logic [2:0] cell_count;
  logic [15:0] dep_limit_mv;
  logic depleted;
  logic bat_present;
  logic adp_present;
  logic adp_below_bat;
  logic rev_trip;
  logic recovered;
  logic sys_high;
  logic timer_run;
  logic timer_done;
  logic [16:0] bat_ext;
  logic [16:0] acp_ext;
  logic [16:0] sys_ext;

  // reset is released through two flip-flops
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // true when a setting lies in one of the two continuous bands
  function automatic logic in_band(input logic [15:0] mv);
    in_band = ((mv >= `BAND_LO_MIN_MV) && (mv <= `BAND_LO_MAX_MV)) ||
              ((mv >= `BAND_HI_MIN_MV) && (mv <= `BAND_HI_MAX_MV));
  endfunction : in_band

  // true when a setting is neither wake level, band value nor above maximum
  function automatic logic out_of_range(input logic [15:0] mv);
    out_of_range = (mv != `VOLT_WAKE_MV) && !in_band(mv) &&
                   (mv <= `BAND_HI_MAX_MV);
  endfunction : out_of_range

  // regulation target for a setting
  function automatic logic [15:0] target_of(input logic [15:0] mv);
    logic [15:0] res;
    res = `TARGET_RESET;
    if (mv == `VOLT_WAKE_MV) begin
      res = `VOLT_WAKE_MV;
    end else if (mv > `BAND_HI_MAX_MV) begin
      res = `BAND_HI_MAX_MV;
    end else if (in_band(mv)) begin
      res = mv & `DAC_STEP_MASK;
    end
    target_of = res;
  endfunction : target_of

  // number of cells implied by a regulation target
  function automatic logic [2:0] cells_of(input logic [15:0] mv);
    if (mv >= `BAND_HI_MIN_MV) begin
      cells_of = `CELLS_HI;
    end else begin
      cells_of = `CELLS_LO;
    end
  endfunction : cells_of

  // control word fields
  assign learn_mode = CTRL_WORD_IN[`CTRL_LEARN_BIT];
  assign dep_code = CTRL_WORD_IN[`CTRL_DEP_MSB:`CTRL_DEP_LSB];

  // depleted threshold scaled by the cell count
  always_comb begin
    logic [15:0] per_cell;
    logic [18:0] prod;
    per_cell = `DEP_BASE_MV + (`DEP_STEP_MV * {13'h0000, dep_code});
    cell_count = cells_of(st_reg.target_reg);
    prod = 19'(per_cell) * 19'(cell_count);
    dep_limit_mv = prod[15:0];
  end

  // synchronised comparator levels
  assign bat_present = st_reg.sync2.ts_below;
  assign adp_present = st_reg.sync2.adet_above;

  // rail comparisons, widened so margins cannot overflow
  assign bat_ext = {1'b0, RAILS_IN.bat_mv};
  assign acp_ext = {1'b0, RAILS_IN.acp_mv};
  assign sys_ext = {1'b0, RAILS_IN.sys_mv};
  assign depleted = RAILS_IN.bat_mv < dep_limit_mv;
  assign adp_below_bat = bat_ext > acp_ext;
  assign rev_trip = acp_ext < (bat_ext + `REV_MARGIN_MV);
  assign recovered = acp_ext >= (bat_ext + `REV_MARGIN_MV + `HYST_MV);
  assign sys_high = sys_ext > (bat_ext + `SYS_MARGIN_MV);

  // deglitch runs only while waiting with the rail recovered
  assign timer_run = (st_reg.byp_reg == BYP_WAIT) && recovered;

  deglitch_timer #(
    .CYCLES(DEGLITCH_CYCLES)
  ) u_bypass_deglitch (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .run_in(timer_run),
    .done_out(timer_done)
  );

  // next-state logic
  always_comb begin
    logic charge_ok;
    logic learn_switch;
    st_next = st_reg;
    charge_ok = 1'b0;
    learn_switch = 1'b0;

    // two-stage synchronisers for the raw comparator pins
    st_next.sync1 = PINS_IN;
    st_next.sync2 = st_reg.sync1;

    // charge-voltage setting, range check and target
    if (VOLT_WR_IN) begin
      st_next.volt_reg = VOLT_DATA_IN;
    end
    st_next.target_reg = target_of(st_reg.volt_reg);
    st_next.vor_reg = out_of_range(st_reg.volt_reg);

    // bypass switch: immediate off, deglitched on
    case (st_reg.byp_reg)
      BYP_OFF: begin
        if (recovered) begin
          st_next.byp_reg = BYP_WAIT;
        end
      end
      BYP_WAIT: begin
        if (rev_trip || !recovered) begin
          st_next.byp_reg = BYP_OFF;
        end else if (timer_done) begin
          st_next.byp_reg = BYP_ON;
        end
      end
      BYP_ON: begin
        if (rev_trip) begin
          st_next.byp_reg = BYP_OFF;
        end
      end
      default: begin
        st_next.byp_reg = BYP_OFF;
      end
    endcase

    // learn cycle switchover when the battery is depleted
    learn_switch = learn_mode && depleted;
    st_next.drv_reg.bat_drive = !learn_switch && !sys_high;
    st_next.drv_reg.ac_drive = adp_present && (!learn_mode || depleted);

    // a trip drops the bypass in the same cycle it is seen
    st_next.drv_reg.bypass_drive = (st_next.byp_reg == BYP_ON) && !rev_trip;

    // charging needs adapter, battery and a usable voltage setting
    charge_ok = adp_present && bat_present;
    st_next.drv_reg.charge_en = charge_ok && !out_of_range(st_reg.volt_reg) &&
                                !st_reg.vor_reg;
    st_next.drv_reg.alarm = st_reg.vor_reg;

    // regulator reset and serial bus wake-up
    st_next.drv_reg.por_start = st_reg.sync2.adet_wake && st_reg.sync2.vcc_ok;
    st_next.drv_reg.smbus_en = st_reg.sync2.adet_wake && st_reg.sync2.vcc_ok;

    // status word upper bits track the current conditions
    st_next.status_reg = `STATUS_RESET;
    st_next.status_reg[`ST_DEPLETED_BIT] = depleted;
    st_next.status_reg[`ST_VOR_BIT] = out_of_range(st_reg.volt_reg); // with target
    st_next.status_reg[`ST_ADP_LOW_BIT] = adp_below_bat;
    st_next.status_reg[`ST_BAT_PRES_BIT] = bat_present;
    st_next.status_reg[`ST_ADP_PRES_BIT] = adp_present;
  end

  // state register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.sync1 <= '0;
      st_reg.sync2 <= '0;
      st_reg.volt_reg <= `VOLT_RESET;
      st_reg.target_reg <= `TARGET_RESET;
      st_reg.vor_reg <= 1'b0;
      st_reg.status_reg <= `STATUS_RESET;
      st_reg.byp_reg <= BYP_OFF;
      st_reg.drv_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register
  assign VOLT_WORD_OUT = st_reg.volt_reg;
  assign STATUS_WORD_OUT = st_reg.status_reg;
  assign REG_TARGET_MV_OUT = st_reg.target_reg;
  assign DRIVES_OUT = st_reg.drv_reg;

endmodule : charger_status_upper

// ==== logic/deglitch_timer.sv ====
// counter that reports a condition held for a fixed number of cycles
module deglitch_timer #(
  parameter int CYCLES = 1600000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // condition and result
  input wire logic run_in,
  output logic done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;

  // count while the condition holds, restart when it drops
  always_comb begin
    st_next = st_reg;
    if (!run_in) begin
      st_next.cnt = '0;
      st_next.done = 1'b0;
    end else if (st_reg.cnt == LAST) begin
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_out = st_reg.done;

endmodule : deglitch_timer

// ==== tb/charger_status_checker.sv ====
// assertion checker for the charger status upper-flag block
module charger_status_checker #(
  parameter int DEGLITCH_CYCLES = 1600000
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // register side
  input wire logic [15:0] CTRL_WORD_IN,
  input wire logic VOLT_WR_IN,
  input wire logic [15:0] VOLT_DATA_IN,
  input wire logic [15:0] VOLT_WORD_OUT,
  input wire logic [15:0] STATUS_WORD_OUT,
  // analog side
  input wire charger_status_pkg::rail_levels_t RAILS_IN,
  input wire charger_status_pkg::pin_bits_t PINS_IN,
  // controls
  input wire logic [15:0] REG_TARGET_MV_OUT,
  input wire charger_status_pkg::drive_bits_t DRIVES_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import charger_status_pkg::*;
  logic [2:0] up_cnt;
  logic [31:0] rec_cnt;
  logic live;
  logic bat_hi;
  logic fwd;
  logic rec;
  // live once the internal reset and the pin synchronisers have flushed
  assign live = (up_cnt == 3'h6);
  assign bat_hi = RAILS_IN.bat_mv > RAILS_IN.acp_mv;
  assign fwd = {1'b0, RAILS_IN.acp_mv} >= {1'b0, RAILS_IN.bat_mv} + 17'h0_0096;
  assign rec = {1'b0, RAILS_IN.acp_mv} >= {1'b0, RAILS_IN.bat_mv} + 17'h0_00FA;
  // cycles since release, and length of the current recovery run
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      up_cnt <= 3'h0;
      rec_cnt <= 32'h0000_0000;
    end else begin
      if (!live) up_cnt <= up_cnt + 3'h1;
      rec_cnt <= rec ? rec_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  // bypass steps
  sequence s_reverse;
    live && DRIVES_OUT.bypass_drive && !fwd;
  endsequence
  sequence s_bypass_rise;
    $rose(DRIVES_OUT.bypass_drive);
  endsequence
  a_adp_low: assert property (live |-> STATUS_WORD_OUT[13] == $past(bat_hi))
    else $error("battery-above-adapter flag wrong");
  a_pres_track: assert property (live |-> STATUS_WORD_OUT[14] == $past(PINS_IN.ts_below, 3))
    else $error("battery present flag wrong");
  a_adp_pres: assert property (live |-> STATUS_WORD_OUT[15] == $past(PINS_IN.adet_above, 3))
    else $error("adapter present flag wrong");
  a_low_zero: assert property (STATUS_WORD_OUT[10:0] == 11'h000)
    else $error("low status bits not zero");
  a_vor_target: assert property (STATUS_WORD_OUT[12] |-> REG_TARGET_MV_OUT == 16'h0000)
    else $error("target kept while out of range");
  a_vor_alarm: assert property (live |-> DRIVES_OUT.alarm == $past(STATUS_WORD_OUT[12]))
    else $error("alarm does not follow range flag");
  a_vor_nocharge: assert property (live && $past(STATUS_WORD_OUT[12]) |-> !DRIVES_OUT.charge_en)
    else $error("charging while setting out of range");
  a_clamp_max: assert property (REG_TARGET_MV_OUT <= 16'h4B00)
    else $error("target above maximum");
  a_charge_gate: assert property (DRIVES_OUT.charge_en |-> &STATUS_WORD_OUT[15:14])
    else $error("charging without battery or adapter");
  a_bypass_drop: assert property (s_reverse |-> ##[1:2] !DRIVES_OUT.bypass_drive)
    else $error("bypass left on under reverse margin");
  a_bypass_wait: assert property (s_bypass_rise |-> rec_cnt >= DEGLITCH_CYCLES)
    else $error("bypass on before deglitch");
endmodule : charger_status_checker

bind charger_status_upper charger_status_checker #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_chk (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CTRL_WORD_IN(CTRL_WORD_IN),
  .VOLT_WR_IN(VOLT_WR_IN), .VOLT_DATA_IN(VOLT_DATA_IN), .VOLT_WORD_OUT(VOLT_WORD_OUT),
  .STATUS_WORD_OUT(STATUS_WORD_OUT), .RAILS_IN(RAILS_IN), .PINS_IN(PINS_IN),
  .REG_TARGET_MV_OUT(REG_TARGET_MV_OUT), .DRIVES_OUT(DRIVES_OUT));

// ==== tb/charger_status_upper_bench.sv ====
// self-checking bench for the charger status upper-flag block
`include "charger_status_consts.svh"
module charger_status_upper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import charger_status_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] ctrl = 16'h0000;
  rail_levels_t rails = '0;
  pin_bits_t pins = 4'h0;
  logic vwr;
  logic [15:0] vdata, vword, status, target, thr;
  drive_bits_t drv;
  logic [32:0] ent;
  logic [32:0] expq [$];
  int error_cnt = 0;
  int checked = 0;
  int seed = 88093;
  logic [15:0] vin [7] = '{16'h2328, 16'h2EE5, 16'h4B0F, 16'h3C00, 16'h2000, 16'h3840, 16'h3E7F};
  always #2.5 clk = ~clk;
  host_model u_host (.clk_in(clk), .volt_wr_out(vwr), .volt_data_out(vdata));
  charger_status_upper #(.DEGLITCH_CYCLES(8)) u_dut (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .CTRL_WORD_IN(ctrl), .VOLT_WR_IN(vwr), .VOLT_DATA_IN(vdata), .VOLT_WORD_OUT(vword),
    .STATUS_WORD_OUT(status), .RAILS_IN(rails), .PINS_IN(pins),
    .REG_TARGET_MV_OUT(target), .DRIVES_OUT(drv));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // expected regulation target of a setting
  function automatic logic [15:0] exp_target(input logic [15:0] v);
    if (v == `VOLT_WAKE_MV) return v;
    if (v > `BAND_HI_MAX_MV) return `BAND_HI_MAX_MV;
    if ((v >= `BAND_LO_MIN_MV && v <= `BAND_LO_MAX_MV) || v >= `BAND_HI_MIN_MV)
      return v & `DAC_STEP_MASK;
    return 16'h0000;
  endfunction : exp_target
  task automatic set_volt(input logic [15:0] v);
    expq.push_back({exp_target(v) == 16'h0000, exp_target(v), v});
    u_host.write_volt(v);
    wait_cyc(4);
  endtask : set_volt
  // takes the oldest note at each write and compares the results
  always @(posedge clk) begin
    if (vwr === 1'b1) begin
      ent = expq.pop_front();
      repeat (3) @(negedge clk);
      check("volt word", ent[15:0], vword);
      check("target", ent[31:16], target);
      check("vor", 16'(ent[32]), 16'(status[12]));
      @(negedge clk);
      check("alarm", 16'(ent[32]), 16'(drv.alarm));
      check("charge", 16'(!ent[32]), 16'(drv.charge_en));
    end
  end
  // watchdog
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    wait_cyc(2);
    arst_n = 1'b1;
    pins = 4'hF;
    rails = {16'h2EE0, 16'h300C, 16'h0000};
    wait_cyc(4);
    for (int i = 0; i < 15; i++) set_volt(i < 7 ? vin[i] : 16'($random(seed)));
    $display("test voltage done");
    for (int j = 0; j < 2; j++) begin
      set_volt(j ? 16'h2EE0 : 16'h4B00);
      ctrl = j ? 16'h0E10 : 16'h0010;
      thr = (`DEP_BASE_MV + (j ? 16'h0007 : 16'h0000) * `DEP_STEP_MV) * (j ? 16'h0003 : 16'h0004);
      rails.bat_mv = thr - 16'h0064;
      wait_cyc(3);
      check("depleted", 16'h0001, 16'(status[11]));
      check("bat drive", 16'h0000, 16'(drv.bat_drive));
      check("ac drive", 16'h0001, 16'(drv.ac_drive));
      rails.bat_mv = thr + 16'h0064;
      wait_cyc(3);
      check("depleted", 16'h0000, 16'(status[11]));
      check("ac drive", 16'h0000, 16'(drv.ac_drive));
    end
    ctrl = 16'h0000;
    rails = {16'h2EE0, 16'h300C, 16'h2F80};
    wait_cyc(3);
    check("sys hold", 16'h0000, 16'(drv.bat_drive));
    rails.sys_mv = 16'h2F6C;
    wait_cyc(3);
    check("sys hold", 16'h0001, 16'(drv.bat_drive));
    for (int k = 0; k < 16; k++) begin
      rails.bat_mv = 16'($random(seed));
      rails.acp_mv = 16'($random(seed));
      wait_cyc(1);
      check("bat above", 16'(rails.bat_mv > rails.acp_mv), 16'(status[13]));
    end
    $display("test rails done");
    rails = {16'h2EE0, 16'h300C, 16'h0000};
    for (int k = 0; k < 5; k++) begin
      pins = 4'hF ^ (4'h1 << k);
      wait_cyc(4);
      check("battery", 16'(pins.ts_below), 16'(status[14]));
      check("adapter", 16'(pins.adet_above), 16'(status[15]));
      check("charge", 16'(pins.ts_below && pins.adet_above), 16'(drv.charge_en));
      check("bus", 16'(pins.adet_wake && pins.vcc_ok), 16'(drv.smbus_en));
      check("por", 16'(pins.adet_wake && pins.vcc_ok), 16'(drv.por_start));
    end
    $display("test pins done");
    rails.acp_mv = 16'h2F44;
    wait_cyc(3);
    check("bypass", 16'h0000, 16'(drv.bypass_drive));
    rails.acp_mv = 16'h2FA8;
    wait_cyc(20);
    check("bypass", 16'h0000, 16'(drv.bypass_drive));
    rails.acp_mv = 16'h300C;
    wait_cyc(6);
    check("bypass", 16'h0000, 16'(drv.bypass_drive));
    wait_cyc(8);
    check("bypass", 16'h0001, 16'(drv.bypass_drive));
    rails.acp_mv = 16'h2F44;
    wait_cyc(2);
    check("bypass", 16'h0000, 16'(drv.bypass_drive));
    $display("test bypass done");
    stop_test();
  end
endmodule : charger_status_upper_bench

// ==== tb/host_model.sv ====
// host model that loads charge-voltage settings into the block
module host_model (
  input wire logic clk_in,
  output logic volt_wr_out,
  output logic [15:0] volt_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    volt_wr_out = 1'b0;
    volt_data_out = 16'h0000;
  end
  // one-cycle write pulse; data is scrambled after release
  task automatic write_volt(input logic [15:0] mv);
    @(negedge clk_in);
    volt_wr_out = 1'b1;
    volt_data_out = mv;
    @(negedge clk_in);
    volt_wr_out = 1'b0;
    volt_data_out = ~mv;
  endtask : write_volt
endmodule : host_model
